/* hdl/brl_pkg.sv */
// package for the buck rail-ok and level-select block
// assumes a single 10 MHz clock domain, synchronous active-high reset
package brl_pkg;
    localparam int NUM_RAILS = 4;      // rails 0..3: first, second, third, fourth
    localparam int CODE_W = 7;
    localparam logic [6:0] CODE_OFF = 7'h00;
    // mask reset: only the first rail (or paired rail) watched
    localparam logic [3:0] MASK_RESET = 4'h1;
    localparam int IDX_FIRST = 0;
    localparam int IDX_SECOND = 1;
    localparam int IDX_FOURTH = 3;
    // ramp timing: 10 mV step at 2.5 mV/us -> 4 us; 20 mV step -> 8 us
    localparam int CLK_MHZ = 10;
    localparam int SLEW_UV_PER_US = 2500;
    localparam int STEP_LO_UV = 10000;
    localparam int STEP_HI_UV = 20000;
    localparam int STEP_LO_CYC = STEP_LO_UV * CLK_MHZ / SLEW_UV_PER_US;
    localparam int STEP_HI_CYC = STEP_HI_UV * CLK_MHZ / SLEW_UV_PER_US;
    localparam int TICK_W = 8;
    // phase-force encodings
    localparam logic [1:0] PHASE_AUTO = 2'h0;
    localparam logic [1:0] PHASE_FORCE_DUAL = 2'h1;
    localparam logic [1:0] PHASE_FORCE_SINGLE = 2'h2;
    // pin map source selection
    localparam logic [1:0] PIN_SLEEP = 2'h0;
    localparam logic [1:0] PIN_CTRL_A = 2'h1;
    localparam logic [1:0] PIN_CTRL_B = 2'h2;

    // per-rail level control as software writes it
    typedef struct packed {
        logic [6:0] primary_code;
        logic [6:0] alt_code;
        logic span;
        logic pin_sel_en;
        logic alt_cmd;
        logic [1:0] pin_map;
    } brl_rail_cfg_s;

    // per-rail analog monitor indications
    typedef struct packed {
        logic volt_in_window;
        logic below_ilim;
    } brl_rail_mon_s;
endpackage : brl_pkg

/* hdl/brl_ramp.sv */
// per-rail level ramp: steps the applied code toward the selected target
// assumes target settles between steps; mclk 10 MHz, sync reset
module brl_ramp (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic ramp_en,
    input wire logic span,
    input wire logic [6:0] target_code,
    output logic [6:0] applied_code,
    output logic ramping
);
    logic [6:0] code_reg;
    logic [6:0] code_next;
    logic [7:0] tick_reg;
    logic [7:0] tick_next;
    logic [7:0] step_cyc;

    assign step_cyc = span ? 8'(brl_pkg::STEP_HI_CYC)
                           : 8'(brl_pkg::STEP_LO_CYC);

    // off jumps immediately; otherwise one code per interval when ramping
    always_comb begin
        code_next = code_reg;
        tick_next = tick_reg;
        if (target_code == brl_pkg::CODE_OFF || code_reg == brl_pkg::CODE_OFF
            || !ramp_en) begin
            code_next = target_code;
            tick_next = 8'h00;
        end else if (code_reg != target_code) begin
            if (tick_reg >= step_cyc - 8'h01) begin
                tick_next = 8'h00;
                code_next = (code_reg < target_code) ? code_reg + 7'h01
                                                     : code_reg - 7'h01;
            end else begin
                tick_next = tick_reg + 8'h01;
            end
        end else begin
            tick_next = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            code_reg <= 7'h00;
            tick_reg <= 8'h00;
        end else if (clk_en) begin
            code_reg <= code_next;
            tick_reg <= tick_next;
        end
    end

    assign applied_code = code_reg;
    assign ramping = ramp_en && (code_reg != target_code)
                     && code_reg != brl_pkg::CODE_OFF
                     && target_code != brl_pkg::CODE_OFF;
endmodule : brl_ramp

/* hdl/brl_top.sv */
// top of the buck rail-ok and level-select control
// assumes host drives pins and config; monitor inputs come from analog
module brl_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire brl_pkg::brl_rail_cfg_s [3:0] rail_cfg,
    input wire brl_pkg::brl_rail_mon_s [3:0] rail_mon,
    input wire logic [3:0] rail_ok_mask_a,
    input wire logic rail_ok_mask_wr,
    input wire logic type_current_only,
    input wire logic current_compare_include,
    input wire logic current_compare_ok,
    input wire logic dual_phase_strap,
    input wire logic [1:0] paired_phase_force,
    input wire logic light_load,
    input wire logic sleep_request_pin,
    input wire logic ext_ctrl_pin_a,
    input wire logic ext_ctrl_pin_b,
    output logic rail_ok,
    output logic [3:0] rail_ok_mask_b,
    output logic [6:0] level_code [4],
    output logic [3:0] rail_on,
    output logic [3:0] rail_span,
    output logic dual_phase,
    output logic paired_two_phase_on
);
    logic [2:0] sl_sync_reg, pa_sync_reg, pb_sync_reg;
    logic [2:0] sl_sync_next, pa_sync_next, pb_sync_next;
    logic sl_reg, pa_reg, pb_reg, sl_next, pa_next, pb_next;
    logic [3:0] mask_reg, mask_next;
    logic [3:0] span_reg, span_next;
    logic dual_reg, dual_next, strap_done_reg, strap_done_next;
    logic ok_reg, ok_next, phase_reg, phase_next;
    logic [6:0] target [4];
    logic [3:0] ramping;
    logic [3:0] rail_good;
    logic [3:0] eff_mask;

    // pin synchronisers: change counted when 2nd and 3rd stages agree
    always_comb begin
        sl_sync_next = {sl_sync_reg[1:0], sleep_request_pin};
        pa_sync_next = {pa_sync_reg[1:0], ext_ctrl_pin_a};
        pb_sync_next = {pb_sync_reg[1:0], ext_ctrl_pin_b};
        sl_next = (sl_sync_reg[1] == sl_sync_reg[2]) ? sl_sync_reg[2] : sl_reg;
        pa_next = (pa_sync_reg[1] == pa_sync_reg[2]) ? pa_sync_reg[2] : pa_reg;
        pb_next = (pb_sync_reg[1] == pb_sync_reg[2]) ? pb_sync_reg[2] : pb_reg;
    end

    // strap caught once after reset release; masks and span tracked
    always_comb begin
        strap_done_next = 1'b1;
        dual_next = strap_done_reg ? dual_reg : dual_phase_strap;
        mask_next = rail_ok_mask_wr ? rail_ok_mask_a : mask_reg;
        for (int i = 0; i < 4; i++) begin
            // span latched only while rail is off
            span_next[i] = (target[i] == brl_pkg::CODE_OFF
                            && level_code[i] == brl_pkg::CODE_OFF)
                           ? rail_cfg[i].span : span_reg[i];
        end
    end

    // target selection per rail
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            logic pin_lvl;
            logic use_primary;
            pin_lvl = 1'b0;
            use_primary = 1'b1;
            unique case (rail_cfg[i].pin_map)
                brl_pkg::PIN_SLEEP: pin_lvl = sl_reg;
                brl_pkg::PIN_CTRL_A: pin_lvl = pa_reg;
                brl_pkg::PIN_CTRL_B: pin_lvl = pb_reg;
                default: pin_lvl = 1'b0;
            endcase
            if (rail_cfg[i].pin_sel_en)
                use_primary = pin_lvl;
            else
                use_primary = !rail_cfg[i].alt_cmd;
            // code zero from either source means off
            target[i] = use_primary ? rail_cfg[i].primary_code
                                    : rail_cfg[i].alt_code;
        end
    end

    // ramps; the fourth rail jumps straight to its target, with no slew
    for (genvar g = 0; g < 4; g++) begin : g_ramp
        brl_ramp u_ramp (
            .mclk(mclk),
            .reset(reset),
            .clk_en(clk_en),
            .ramp_en(g != brl_pkg::IDX_FOURTH),
            .span(span_reg[g]),
            .target_code(target[g]),
            .applied_code(level_code[g]),
            .ramping(ramping[g])
        );
    end

    // rail-ok combine: masked or ramping voltage ignored
    always_comb begin
        eff_mask = mask_reg;
        if (dual_reg)
            eff_mask[brl_pkg::IDX_SECOND] = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rail_good[i] = rail_mon[i].below_ilim
                && (type_current_only || ramping[i]
                    || rail_mon[i].volt_in_window);
        end
        ok_next = &(~eff_mask | rail_good)
                  && (!current_compare_include || current_compare_ok);
        // auto sheds at light load unless forced
        unique case (paired_phase_force)
            brl_pkg::PHASE_FORCE_DUAL: phase_next = dual_reg;
            brl_pkg::PHASE_FORCE_SINGLE: phase_next = 1'b0;
            default: phase_next = dual_reg && !light_load;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sl_sync_reg <= 3'h0;
            pa_sync_reg <= 3'h0;
            pb_sync_reg <= 3'h0;
            sl_reg <= 1'b0;
            pa_reg <= 1'b0;
            pb_reg <= 1'b0;
            mask_reg <= brl_pkg::MASK_RESET;
            span_reg <= 4'h0;
            dual_reg <= 1'b0;
            strap_done_reg <= 1'b0;
            ok_reg <= 1'b0;
            phase_reg <= 1'b0;
        end else if (clk_en) begin
            sl_sync_reg <= sl_sync_next;
            pa_sync_reg <= pa_sync_next;
            pb_sync_reg <= pb_sync_next;
            sl_reg <= sl_next;
            pa_reg <= pa_next;
            pb_reg <= pb_next;
            mask_reg <= mask_next;
            span_reg <= span_next;
            dual_reg <= dual_next;
            strap_done_reg <= strap_done_next;
            ok_reg <= ok_next;
            phase_reg <= phase_next;
        end
    end

    assign rail_ok = ok_reg;
    assign rail_ok_mask_b = mask_reg;
    assign rail_span = span_reg;
    assign dual_phase = dual_reg;
    assign paired_two_phase_on = phase_reg;
    always_comb begin
        for (int i = 0; i < 4; i++)
            rail_on[i] = level_code[i] != brl_pkg::CODE_OFF;
    end

    // checks: mask reset value and the rail-ok combine
    AST_MASK_RESET: assert property (
        @(posedge mclk) $fell(reset) |-> mask_reg == brl_pkg::MASK_RESET)
        else $error("mask not at reset value");
    AST_BAD_DROPS: assert property (
        @(posedge mclk) disable iff (reset)
        clk_en && mask_reg[0] && !rail_mon[0].below_ilim |=> !rail_ok)
        else $error("rail-ok stayed high on over-current");
    // a ramping rail with good current must not pull rail-ok low
    AST_RAMP_HOLD: assert property (
        @(posedge mclk) disable iff (reset)
        clk_en && ramping[0] && rail_mon[0].below_ilim
        && eff_mask == 4'h1 && !current_compare_include |=> rail_ok)
        else $error("ramp disturbed rail-ok");
    AST_CMP_INC: assert property (
        @(posedge mclk) disable iff (reset)
        clk_en && current_compare_include && !current_compare_ok |=> !rail_ok)
        else $error("compare not included");
    // phase force
    AST_FORCE_SINGLE: assert property (
        @(posedge mclk) disable iff (reset)
        clk_en && paired_phase_force == brl_pkg::PHASE_FORCE_SINGLE
        |=> !paired_two_phase_on)
        else $error("force single ignored");
    // level source selection, off codes and strap hold
    AST_OFF_JUMP: assert property (
        @(posedge mclk) disable iff (reset)
        clk_en && target[2] == brl_pkg::CODE_OFF
        |=> level_code[2] == brl_pkg::CODE_OFF)
        else $error("zero code did not turn rail off");
    AST_CMD_ALT: assert property (
        @(posedge mclk) disable iff (reset)
        clk_en && !rail_cfg[1].pin_sel_en && rail_cfg[1].alt_cmd
        && rail_cfg[1].alt_code == brl_pkg::CODE_OFF
        |=> level_code[1] == brl_pkg::CODE_OFF)
        else $error("command bit did not pick the alternate code");
    AST_FOURTH_JUMP: assert property (
        @(posedge mclk) disable iff (reset)
        clk_en |=> level_code[3] == $past(target[3]))
        else $error("fourth rail did not jump");
    AST_STRAP_HOLD: assert property (
        @(posedge mclk) disable iff (reset)
        strap_done_reg |=> $stable(dual_reg))
        else $error("phase strap changed");
endmodule : brl_top

/* verification/brl_host.sv */
// host-side driver of the three level-select pins
// assumes the bench sets pin_req just after a rising edge of mclk
module brl_host (
    input wire logic mclk,
    input wire logic [2:0] pin_req,
    output logic sleep_request_pin,
    output logic ext_ctrl_pin_a,
    output logic ext_ctrl_pin_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins idle inactive until the bench asks
    initial {ext_ctrl_pin_b, ext_ctrl_pin_a, sleep_request_pin} = 3'h0;
    // relaunched off the edge, as an unsynchronised host would
    always @(posedge mclk) begin
        {ext_ctrl_pin_b, ext_ctrl_pin_a, sleep_request_pin} <= pin_req;
    end
endmodule : brl_host

/* verification/buck_rail_ok_and_level_select_tb.sv */
// self-checking bench: rail-ok, level source, ramp, span, phase force
// assumes brl_pkg, brl_top and brl_host compiled before this file
module buck_rail_ok_and_level_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    brl_pkg::brl_rail_cfg_s [3:0] cfg = '0;
    brl_pkg::brl_rail_mon_s [3:0] mon = '0;
    logic [3:0] mask = 4'h0;
    logic mask_wr = 1'b0, cur_only = 1'b0, inc = 1'b0, cmp_ok = 1'b0;
    logic strap = 1'b0, light = 1'b0;
    logic [1:0] force_sel = 2'h0;
    logic en = 1'b1;
    logic [2:0] pin_req = 3'h0;
    logic s_pin, a_pin, b_pin, rail_ok, dual, two_ph;
    logic [3:0] mask_b, on, span_o;
    logic [6:0] code [4];
    int error_cnt = 0, n_compared = 0, seed = 32'h2b760603, i, j;
    always #50 mclk = ~mclk;
    brl_host host_u (.mclk(mclk), .pin_req(pin_req),
        .sleep_request_pin(s_pin), .ext_ctrl_pin_a(a_pin),
        .ext_ctrl_pin_b(b_pin));
    brl_top dut_u (.mclk(mclk), .reset(reset), .clk_en(en),
        .rail_cfg(cfg), .rail_mon(mon), .rail_ok_mask_a(mask),
        .rail_ok_mask_wr(mask_wr), .type_current_only(cur_only),
        .current_compare_include(inc), .current_compare_ok(cmp_ok),
        .dual_phase_strap(strap), .paired_phase_force(force_sel),
        .light_load(light), .sleep_request_pin(s_pin),
        .ext_ctrl_pin_a(a_pin), .ext_ctrl_pin_b(b_pin),
        .rail_ok(rail_ok), .rail_ok_mask_b(mask_b), .level_code(code),
        .rail_on(on), .rail_span(span_o), .dual_phase(dual),
        .paired_two_phase_on(two_ph));
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // wait n edges, then look at settled outputs mid-cycle
    task automatic look(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : look
    // integer model: masked rails count as good, second rail off in dual
    function automatic logic exp_ok(input logic d);
        logic r;
        r = inc ? cmp_ok : 1'b1;
        for (int k = 0; k < 4; k++)
            if (mask[k] && !(d && k == 1))
                r &= mon[k].below_ilim & (cur_only | mon[k].volt_in_window);
        return r;
    endfunction : exp_ok
    task automatic set_mask(input logic [3:0] m);
        mask <= m;
        mask_wr <= 1'b1;
        @(posedge mclk);
        mask_wr <= 1'b0;
    endtask : set_mask
    task automatic do_reset(input logic s);
        strap <= s;
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        look(0);
        chk("mask_b", 8'(brl_pkg::MASK_RESET), 8'(mask_b));
        chk("code0", 8'(brl_pkg::CODE_OFF), 8'(code[0]));
        @(posedge mclk);
    endtask : do_reset
    // random monitors, masks and modes with all rails steady
    task automatic okay_test(input logic d);
        for (j = 0; j < 4; j++) cfg[j].primary_code <= 7'h20;
        repeat (4) @(posedge mclk);
        for (i = 0; i < 40; i++) begin
            if (i % 8 == 0) set_mask(4'($random(seed)));
            mon <= 8'($random(seed));
            {cur_only, inc, cmp_ok} <= 3'($random(seed));
            look(2);
            chk("rail_ok", 8'(exp_ok(d)),
                8'(rail_ok));
            @(posedge mclk);
        end
        look(0);
        chk("dual", 8'(d), 8'(dual));
        @(posedge mclk);
        $display("rail-ok test done");
    endtask : okay_test
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_sim();
    end
    initial begin
        do_reset(1'b0);
        okay_test(1'b0);
        // third rail follows whichever pin it is mapped to; map 3 is none
        cfg[2].pin_sel_en <= 1'b1;
        for (i = 0; i < 12; i++) begin
            cfg[2].pin_map <= 2'(i % 4);
            pin_req <= 3'($random(seed));
            look(8);
            chk("code2", ((4'(pin_req) >> (i % 4)) & 4'h1) != 4'h0
                ? 8'h20 : 8'h00, 8'(code[2]));
            @(posedge mclk);
        end
        cfg[2].pin_sel_en <= 1'b0;
        // command bit and zero primary on the second rail
        for (i = 0; i < 4; i++) begin
            cfg[1].alt_cmd <= i[0];
            cfg[1].primary_code <= i[1] ? 7'h00 : 7'h20;
            look(3);
            chk("code1", i == 0 ? 8'h20 : 8'h00,
                8'(code[1]));
            chk("on1", 8'(i == 0), 8'(on[1]));
            @(posedge mclk);
        end
        cfg[1].alt_cmd <= 1'b0;
        // two-step ramp; window goes bad mid-ramp and must not show
        set_mask(4'h1);
        {cur_only, inc} <= 2'h0;
        mon <= 8'hFF;
        repeat (3) @(posedge mclk);
        cfg[0].primary_code <= 7'h22;
        // host moves the unramped fourth rail one code at a time
        cfg[3].primary_code <= 7'h21;
        repeat (2) @(posedge mclk);
        mon[0].volt_in_window <= 1'b0;
        look(0);
        chk("code3", 8'h21, 8'(code[3]));
        // last edge before and first edge of each step; target moved
        // two edges before the first look
        for (i = 0; i < 4; i++) begin
            look(i[0] ? 1 : brl_pkg::STEP_LO_CYC - (i == 0 ? 3 : 1));
            chk("code0", 8'h20 + 8'((i + 1) / 2),
                8'(code[0]));
            chk("rail_ok", 8'h01, 8'(rail_ok));
        end
        look(1);
        chk("rail_ok", 8'h00, 8'(rail_ok));
        // span is refused while the rail is on, taken once off
        @(posedge mclk);
        cfg[0].span <= 1'b1;
        look(3);
        chk("span0", 8'h00, 8'(span_o[0]));
        @(posedge mclk);
        cfg[0].primary_code <= 7'h00;
        look(4);
        chk("span0", 8'h01, 8'(span_o[0]));
        @(posedge mclk);
        $display("level test done");
        do_reset(1'b1);
        okay_test(1'b1);
        // paired rail masked so a phase drop cannot pull rail-ok low
        set_mask(4'hE);
        // light load is not no load, so forcing dual stays legal
        for (i = 0; i < 6; i++) begin
            force_sel <= 2'(i % 3);
            light <= i[2] | i[1] & i[0];
            look(3);
            chk("two_ph", force_sel == brl_pkg::PHASE_FORCE_DUAL ? 8'h01
                : force_sel == brl_pkg::PHASE_FORCE_SINGLE ? 8'h00
                : 8'(!light), 8'(two_ph));
            chk("rail_ok", 8'(exp_ok(1'b1)),
                8'(rail_ok));
            @(posedge mclk);
        end
        // frozen enable: a new force must wait until enable returns
        en <= 1'b0;
        force_sel <= brl_pkg::PHASE_FORCE_DUAL;
        look(3);
        chk("two_ph", 8'h00, 8'(two_ph));
        @(posedge mclk);
        en <= 1'b1;
        look(1);
        chk("two_ph", 8'h01, 8'(two_ph));
        $display("phase test done");
        end_sim();
    end
endmodule : buck_rail_ok_and_level_select_tb
